// file: rtl/apm_host_defs.svh
// Purpose: timing and field constants for the page mapper host controller
// Assumes: clock MCLK at 100 MHz, period 10 ns
// Notes:   times in ns, cycle counts derived by rounding up
`ifndef APM_HOST_DEFS_SVH
`define APM_HOST_DEFS_SVH

`define APM_CLK_PERIOD_NS   10
`define APM_T_SETUP_NS      20
`define APM_T_STROBE_NS     75
`define APM_T_HOLD_NS       20
`define APM_T_READ_NS       75
`define APM_CYC(ns)         (((ns) + `APM_CLK_PERIOD_NS - 1) / `APM_CLK_PERIOD_NS)
`define APM_SETUP_CYC       `APM_CYC(`APM_T_SETUP_NS)
`define APM_STROBE_CYC      `APM_CYC(`APM_T_STROBE_NS)
`define APM_HOLD_CYC        `APM_CYC(`APM_T_HOLD_NS)
`define APM_READ_CYC        `APM_CYC(`APM_T_READ_NS)
`define APM_SYNC_CYC        3
`define APM_ENTRY_W         12
`define APM_INDEX_W         4
`define APM_PASS_LSB        8
`define APM_CNT_W           4

`endif

// file: rtl/apm_pkg.sv
// Purpose: types for the page mapper host controller
// Assumes: used with apm_host_defs.svh
// Notes:   none
package apm_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD   = 3'b011,
        ST_READ   = 3'b100,
        ST_DONE   = 3'b101
    } apm_state_e;
endpackage

// file: rtl/apm_sync.sv
// Purpose: three-flop input synchroniser
// Assumes: asynchronous input
// Notes:   change counts once second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module apm_sync #(
    parameter int W = 1
) (
    input  wire logic         MCLK,
    input  wire logic         NRST,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    if (W < 1) begin : g_bad_width
        $error("apm_sync: width must be at least one");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } apm_sync_s;

    apm_sync_s    st_reg;
    apm_sync_s    st_next;
    logic [W-1:0] q_pick;

    // ---------------------------------------------------------------
    // per-bit agreement
    // ---------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign q_pick[i] = (st_reg.s2[i] == st_reg.s3[i]) ? st_reg.s3[i] : st_reg.q[i];
    end

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.q  = q_pick;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign q = st_reg.q;
endmodule // apm_sync
`default_nettype wire

// file: rtl/apm_host.sv
// Purpose: host controller driving a page mapper through its pins
// Assumes: single clock MCLK 100 MHz, NRST async active low
// Notes:   user side takes one map access or one mapping setup at a time
// Contract
// - Select low: chosen entry read or written, direction from read_not_write.
// - Host sets select, direction, index before strobe; holds all after rise.
// - Host selects only the one mapper it accesses.
// - Host routes upper four CPU address bits to translate_index.
`timescale 1ns/1ps
`default_nettype none
`include "apm_host_defs.svh"
module apm_host
    import apm_pkg::*;
#(
    parameter int EW     = `APM_ENTRY_W,
    parameter int IW     = `APM_INDEX_W,
    parameter int CPU_AW = 16
) (
    input  wire logic            MCLK,
    input  wire logic            NRST,
    // user side
    input  wire logic            REQ_VALID,
    input  wire logic            REQ_WRITE,
    input  wire logic [IW-1:0]   REQ_INDEX,
    input  wire logic [EW-1:0]   REQ_WDATA,
    output logic                 REQ_READY,
    output logic                 RSP_VALID,
    output logic      [EW-1:0]   RSP_RDATA,
    input  wire logic            CPU_MAP_MODE,
    input  wire logic            CPU_OUT_EN,
    input  wire logic            CPU_LATCH_OPEN,
    input  wire logic [CPU_AW-1:0] CPU_ADDR,
    output logic      [CPU_AW-IW+EW-1:0] SYS_ADDR,
    // mapper pins
    output logic                 UNIT_SEL_N,
    output logic                 READ_NOT_WRITE,
    output logic                 STROBE_N,
    output logic      [IW-1:0]   IO_REGISTER_INDEX,
    output logic      [IW-1:0]   TRANSLATE_INDEX,
    output logic                 TRANSLATE_MODE_N,
    output logic                 OUTPUT_DRIVE_ENABLE_N,
    output logic                 OUTPUT_LATCH_TRANSPARENT,
    input  wire logic [EW-1:0]   DATA_IN,
    output logic      [EW-1:0]   DATA_OUT,
    output logic                 DATA_OE_N,
    input  wire logic [EW-1:0]   TRANSLATED_ADDRESS
);
    if (EW != `APM_ENTRY_W || IW != `APM_INDEX_W || CPU_AW <= IW) begin : g_bad_width
        $error("apm_host: unsupported widths");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        apm_state_e                st;
        logic [`APM_CNT_W-1:0]     cnt;
        logic                      wr;
        logic [IW-1:0]             idx;
        logic [EW-1:0]             wdata;
        logic [EW-1:0]             rdata;
        logic                      rsp;
        logic                      sel_n;
        logic                      rnw;
        logic                      stb_n;
        logic                      oe_n;
        logic [CPU_AW-IW-1:0]      low_addr;
        logic [IW-1:0]             tidx;
        logic                      mm_n;
        logic                      me_n;
        logic                      lat;
    } apm_host_s;

    apm_host_s s_reg;
    apm_host_s s_next;
    logic [EW-1:0] din_sync;

    apm_sync #(.W(EW)) u_din_sync (
        .MCLK (MCLK),
        .NRST (NRST),
        .d    (DATA_IN),
        .q    (din_sync)
    );

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        s_next     = s_reg;
        s_next.rsp = 1'b0;
        // mapping drive follows cpu side in every state
        s_next.tidx     = CPU_ADDR[CPU_AW-1 -: IW];
        s_next.low_addr = CPU_ADDR[CPU_AW-IW-1:0];
        s_next.mm_n     = ~CPU_MAP_MODE;
        s_next.me_n     = ~CPU_OUT_EN;
        s_next.lat      = CPU_LATCH_OPEN;
        case (s_reg.st)
            ST_IDLE: begin
                if (REQ_VALID) begin
                    s_next.wr    = REQ_WRITE;
                    s_next.idx   = REQ_INDEX;
                    s_next.wdata = REQ_WDATA;
                    s_next.sel_n = 1'b0;
                    s_next.rnw   = ~REQ_WRITE;
                    s_next.oe_n  = ~REQ_WRITE;
                    s_next.cnt   = `APM_CNT_W'(`APM_SETUP_CYC - 1);
                    s_next.st    = REQ_WRITE ? ST_SETUP : ST_READ;
                    if (!REQ_WRITE) begin
                        s_next.cnt = `APM_CNT_W'(`APM_READ_CYC + `APM_SYNC_CYC);
                    end
                end
            end
            ST_SETUP: begin
                if (s_reg.cnt == '0) begin
                    s_next.stb_n = 1'b0;
                    s_next.cnt   = `APM_CNT_W'(`APM_STROBE_CYC - 1);
                    s_next.st    = ST_STROBE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            ST_STROBE: begin
                if (s_reg.cnt == '0) begin
                    s_next.stb_n = 1'b1;
                    s_next.cnt   = `APM_CNT_W'(`APM_HOLD_CYC - 1);
                    s_next.st    = ST_HOLD;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            ST_HOLD: begin
                if (s_reg.cnt == '0) begin
                    s_next.st = ST_DONE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            ST_READ: begin
                // wait access time plus synchroniser latency
                if (s_reg.cnt == '0) begin
                    s_next.rdata = din_sync;
                    s_next.st    = ST_DONE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            ST_DONE: begin
                s_next.sel_n = 1'b1;
                s_next.rnw   = 1'b1;
                s_next.oe_n  = 1'b1;
                s_next.rsp   = 1'b1;
                s_next.st    = ST_IDLE;
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            s_reg       <= '0;
            s_reg.st    <= ST_IDLE;
            s_reg.sel_n <= 1'b1;
            s_reg.rnw   <= 1'b1;
            s_reg.stb_n <= 1'b1;
            s_reg.oe_n  <= 1'b1;
            s_reg.mm_n  <= 1'b1;
            s_reg.me_n  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign REQ_READY                = (s_reg.st == ST_IDLE);
    assign RSP_VALID                = s_reg.rsp;
    assign RSP_RDATA                = s_reg.rdata;
    assign UNIT_SEL_N               = s_reg.sel_n;
    assign READ_NOT_WRITE           = s_reg.rnw;
    assign STROBE_N                 = s_reg.stb_n;
    assign IO_REGISTER_INDEX        = s_reg.idx;
    assign DATA_OUT                 = s_reg.wdata;
    assign DATA_OE_N                = s_reg.oe_n;
    assign TRANSLATE_INDEX          = s_reg.tidx;
    assign TRANSLATE_MODE_N         = s_reg.mm_n;
    assign OUTPUT_DRIVE_ENABLE_N    = s_reg.me_n;
    assign OUTPUT_LATCH_TRANSPARENT = s_reg.lat;
    assign SYS_ADDR                 = {TRANSLATED_ADDRESS, s_reg.low_addr};
endmodule // apm_host
`default_nettype wire

// file: tb/apm_mapper_model.sv
// Purpose: behavioural page mapper on the far side of the host controller
// Assumes: host pins as driven by apm_host
// Notes:   released data bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module apm_mapper_model #(
    parameter bit LATCHED = 1'b1,
    parameter int ACC_NS  = 75
) (
    input  wire logic        unit_sel_n,
    input  wire logic        read_not_write,
    input  wire logic        strobe_n,
    input  wire logic [3:0]  io_register_index,
    input  wire logic [3:0]  translate_index,
    input  wire logic        translate_mode_n,
    input  wire logic        output_drive_enable_n,
    input  wire logic        output_latch_transparent,
    input  wire logic [11:0] d_bus,
    output logic      [11:0] data_q,
    output wire       [11:0] translated_address
);
    logic [11:0] mem [16]; // no reset value
    logic [11:0] rd_v, last, sel_v, q_lat;
    wire         rd_on = !unit_sel_n && read_not_write;
    always @(posedge strobe_n) if (!unit_sel_n && !read_not_write) mem[io_register_index] <= d_bus;
    assign #(ACC_NS) rd_v = mem[io_register_index];
    always @* if (rd_on) last = rd_v;
    assign data_q = rd_on ? rd_v : ~last;
    assign sel_v = translate_mode_n ? {translate_index, 8'h00} : mem[translate_index];
    always @* if (!LATCHED || output_latch_transparent) q_lat = sel_v;
    assign translated_address = output_drive_enable_n ? 12'hzzz : q_lat;
endmodule // apm_mapper_model
`default_nettype wire

// file: tb/apm_host_checker.sv
// Purpose: pin sequence checks on the page mapper host controller
// Assumes: bound to apm_host
// Notes:   answer bounds allow a little slack around the fixed latencies
`timescale 1ns/1ps
`default_nettype none
module apm_host_checker #(
    parameter int EW     = 12,
    parameter int IW     = 4,
    parameter int CPU_AW = 16
) (
    input wire logic              MCLK,
    input wire logic              NRST,
    input wire logic              REQ_VALID,
    input wire logic              REQ_WRITE,
    input wire logic              REQ_READY,
    input wire logic              RSP_VALID,
    input wire logic              CPU_MAP_MODE,
    input wire logic              CPU_OUT_EN,
    input wire logic [CPU_AW-1:0] CPU_ADDR,
    input wire logic              UNIT_SEL_N,
    input wire logic              READ_NOT_WRITE,
    input wire logic              STROBE_N,
    input wire logic [IW-1:0]     TRANSLATE_INDEX,
    input wire logic              TRANSLATE_MODE_N,
    input wire logic              OUTPUT_DRIVE_ENABLE_N,
    input wire logic [EW-1:0]     DATA_OUT,
    input wire logic              DATA_OE_N
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    wire take = REQ_VALID && REQ_READY;
    wire [IW-1:0] cpu_top = CPU_ADDR[CPU_AW-1 -: IW];
    sequence s_strobe_low; !STROBE_N [*8] ##1 STROBE_N; endsequence
    sequence s_hold; (!UNIT_SEL_N && !READ_NOT_WRITE) [*2]; endsequence
    a_strobe_setup: assert property ($fell(STROBE_N) |-> !$past(UNIT_SEL_N, 2) && !$past(READ_NOT_WRITE, 2))
        else $error("strobe fell without setup");
    a_strobe_width: assert property ($fell(STROBE_N) |-> s_strobe_low)
        else $error("strobe pulse width wrong");
    a_write_hold: assert property ($rose(STROBE_N) |-> s_hold)
        else $error("select released too early");
    a_data_stable: assert property (!STROBE_N |-> $stable(DATA_OUT) && !DATA_OE_N)
        else $error("write data moved under strobe");
    a_bus_release: assert property (!DATA_OE_N |-> !UNIT_SEL_N && !READ_NOT_WRITE)
        else $error("host drives bus outside write");
    a_write_answer: assert property (take && REQ_WRITE |-> ##[13:16] RSP_VALID)
        else $error("write answer missing");
    a_read_answer: assert property (take && !REQ_WRITE |-> ##[13:15] RSP_VALID)
        else $error("read answer missing");
    a_read_nostrobe: assert property (take && !REQ_WRITE |=> STROBE_N [*8])
        else $error("strobe during read");
    a_busy_refuse: assert property (take |=> !REQ_READY [*8])
        else $error("ready while busy");
    a_mode_copy: assert property ($past(NRST) |-> TRANSLATE_MODE_N == !$past(CPU_MAP_MODE)
        && OUTPUT_DRIVE_ENABLE_N == !$past(CPU_OUT_EN)) else $error("mode pins wrong");
    a_index_route: assert property ($past(NRST) |-> TRANSLATE_INDEX == $past(cpu_top))
        else $error("upper address not routed");
endmodule // apm_host_checker
bind apm_host apm_host_checker #(.EW(EW), .IW(IW), .CPU_AW(CPU_AW)) u_chk (
    .MCLK(MCLK), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .CPU_MAP_MODE(CPU_MAP_MODE),
    .CPU_OUT_EN(CPU_OUT_EN), .CPU_ADDR(CPU_ADDR), .UNIT_SEL_N(UNIT_SEL_N),
    .READ_NOT_WRITE(READ_NOT_WRITE), .STROBE_N(STROBE_N), .TRANSLATE_INDEX(TRANSLATE_INDEX),
    .TRANSLATE_MODE_N(TRANSLATE_MODE_N), .OUTPUT_DRIVE_ENABLE_N(OUTPUT_DRIVE_ENABLE_N),
    .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N));
`default_nettype wire

// file: tb/apm_host_tb.sv
// Purpose: self-checking bench for the page mapper host controller
// Assumes: mapper model on the pin side
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module apm_host_tb;
    logic        mclk, nrst, rv, rw, rdy, rsp, mm, oe, lo, sel_n, rnw, stb_n, tm_n, od_n, lt, doe_n;
    logic [3:0]  ri, rsi, ti;
    logic [11:0] wd, rd, dout, dq;
    logic [15:0] ca;
    logic [23:0] sa;
    wire  [11:0] ta;
    wire  [11:0] ta_u;
    logic [11:0] dq_u;
    wire  [11:0] dbus = !doe_n ? dout : dq;
    int          n_fail, samples_checked;
    apm_host dut (.MCLK(mclk), .NRST(nrst), .REQ_VALID(rv), .REQ_WRITE(rw), .REQ_INDEX(ri),
        .REQ_WDATA(wd), .REQ_READY(rdy), .RSP_VALID(rsp), .RSP_RDATA(rd), .CPU_MAP_MODE(mm),
        .CPU_OUT_EN(oe), .CPU_LATCH_OPEN(lo), .CPU_ADDR(ca), .SYS_ADDR(sa), .UNIT_SEL_N(sel_n),
        .READ_NOT_WRITE(rnw), .STROBE_N(stb_n), .IO_REGISTER_INDEX(rsi), .TRANSLATE_INDEX(ti),
        .TRANSLATE_MODE_N(tm_n), .OUTPUT_DRIVE_ENABLE_N(od_n), .OUTPUT_LATCH_TRANSPARENT(lt),
        .DATA_IN(dbus), .DATA_OUT(dout), .DATA_OE_N(doe_n), .TRANSLATED_ADDRESS(ta));
    apm_mapper_model u_map (.unit_sel_n(sel_n), .read_not_write(rnw), .strobe_n(stb_n),
        .io_register_index(rsi), .translate_index(ti), .translate_mode_n(tm_n),
        .output_drive_enable_n(od_n), .output_latch_transparent(lt), .d_bus(dbus),
        .data_q(dq), .translated_address(ta));
    apm_mapper_model #(.LATCHED(1'b0)) u_map_u (.unit_sel_n(sel_n), .read_not_write(rnw),
        .strobe_n(stb_n), .io_register_index(rsi), .translate_index(ti),
        .translate_mode_n(tm_n), .output_drive_enable_n(od_n), .output_latch_transparent(lt),
        .d_bus(dbus), .data_q(dq_u), .translated_address(ta_u));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [11:0] pat(input logic [3:0] i);
        return {i, ~i, 4'h3};
    endfunction
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic acc(input logic w, input logic [3:0] i, input logic [11:0] d);
        int k;
        rv = 1'b1; rw = w; ri = i; wd = d;
        step(1);
        rv = 1'b0;
        k = 0;
        while (rsp !== 1'b1 && k < 30) begin
            step(1);
            k++;
        end
        if (k == 30) begin
            n_fail++;
            results();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_regs;
        for (int i = 0; i < 16; i++) acc(1'b1, 4'(i), pat(4'(i)));
        for (int i = 15; i >= 0; i--) begin
            acc(1'b0, 4'(i), 12'h000);
            chk(rd, pat(4'(i)));
        end
    endtask
    task automatic s_map;
        oe = 1'b1; lo = 1'b1; mm = 1'b1;
        for (int i = 0; i < 16; i++) begin
            ca = {4'(i), 12'h5a5 ^ 12'(i)};
            step(3);
            chk(sa, {pat(4'(i)), ca[11:0]});
        end
        mm = 1'b0;
        for (int i = 0; i < 16; i++) begin
            ca = {4'(i), 12'h0f0};
            step(3);
            chk(sa, {4'(i), 8'h00, ca[11:0]});
        end
        mm = 1'b1; ca = 16'h2000;
        step(3);
        lo = 1'b0;
        step(3);
        ca = 16'h9000;
        step(3);
        chk(sa[23:12], pat(4'h2));
        chk(ta_u, pat(4'h9));
        lo = 1'b1;
        step(3);
        chk(sa[23:12], pat(4'h9));
        oe = 1'b0;
        step(3);
        chk({sa[23:12], 12'h000}, 24'hzz_z000);
    endtask
    initial begin
        n_fail = 0; samples_checked = 0;
        nrst = 1'b0; rv = 1'b0; rw = 1'b0; ri = 4'h0; wd = 12'h000;
        mm = 1'b0; oe = 1'b0; lo = 1'b0; ca = 16'h0000;
        step(5);
        chk({sel_n, stb_n, doe_n, rdy}, 24'h00_000f);
        nrst = 1'b1;
        s_regs();
        s_map();
        results();
    end
endmodule // apm_host_tb
`default_nettype wire
